//--- rtl/ptb_defs.svh
`ifndef PTB_DEFS_SVH
`define PTB_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PTB_OFF_CONTROL     12'h000
`define PTB_OFF_STATUS      12'h004
`define PTB_OFF_MASK        12'h008

// ****************************************************************
// timebase_control field positions
// ****************************************************************
`define PTB_CTL_ON_BIT      1
`define PTB_CTL_IRQEN_BIT   2
`define PTB_CTL_ACK_BIT     3
`define PTB_CTL_TAP_LSB     4
`define PTB_CTL_TAP_MSB     6
`define PTB_CTL_FLAG_BIT    7

// ****************************************************************
// event status / mask field positions
// ****************************************************************
`define PTB_EVT_ROLL_BIT    0
`define PTB_EVT_OVR_BIT     1

// ****************************************************************
// reset values
// ****************************************************************
`define PTB_RST_ON          1'b0
`define PTB_RST_IRQEN       1'b0
`define PTB_RST_TAP         3'h0
`define PTB_RST_MASK        2'h3

// ****************************************************************
// divider geometry and tap bit index per select code
// ****************************************************************
`define PTB_DIV_STAGES      15
`define PTB_TAP_IDX_0       4'he
`define PTB_TAP_IDX_1       4'hc
`define PTB_TAP_IDX_2       4'ha
`define PTB_TAP_IDX_3       4'h6
`define PTB_TAP_IDX_4       4'h5
`define PTB_TAP_IDX_5       4'h4
`define PTB_TAP_IDX_6       4'h3
`define PTB_TAP_IDX_7       4'h2

`endif

//--- rtl/ptb_pkg.sv
package ptb_pkg;

  // tap select code, 000 = slowest rate
  typedef logic [2:0] ptb_tap_t;

  // divider chain value
  typedef logic [14:0] ptb_count_t;

  // axi response codes used by the slave
  typedef enum logic [1:0] {
    PTB_RESP_OKAY   = 2'b00,
    PTB_RESP_SLVERR = 2'b10
  } ptb_resp_e;

endpackage

//--- rtl/ptb_div_if.sv
`timescale 1ns/10ps
// control and event link between register block and divider
interface ptb_div_if;
  import ptb_pkg::*;
  logic      run;
  logic      advance;
  ptb_tap_t  tap_sel;
  logic      rollover;

  modport ctrl (output run, output advance, output tap_sel, input rollover);
  modport div  (input run, input advance, input tap_sel, output rollover);
endinterface

//--- rtl/ptb_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for a level from outside the clock domain
module ptb_sync (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_reg <= 1'b0;
      sync_o   <= 1'b0;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

//--- rtl/ptb_divider.sv
`timescale 1ns/10ps
`include "ptb_defs.svh"
// fifteen-stage divider chain with selectable rollover tap
module ptb_divider
  import ptb_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  ptb_div_if.div    dv
);

  ptb_count_t count_reg;
  logic [3:0] tap_idx;
  logic       tap_rise;

  // select code to chain bit index
  always_comb begin
    case (dv.tap_sel)
      3'h0:    tap_idx = `PTB_TAP_IDX_0;
      3'h1:    tap_idx = `PTB_TAP_IDX_1;
      3'h2:    tap_idx = `PTB_TAP_IDX_2;
      3'h3:    tap_idx = `PTB_TAP_IDX_3;
      3'h4:    tap_idx = `PTB_TAP_IDX_4;
      3'h5:    tap_idx = `PTB_TAP_IDX_5;
      3'h6:    tap_idx = `PTB_TAP_IDX_6;
      default: tap_idx = `PTB_TAP_IDX_7;
    endcase
  end

  // tap bit about to go 0->1: all lower stages ones, tap stage zero;
  // the first rise after start is half a period, later ones a full one
  always_comb begin
    tap_rise = ~count_reg[tap_idx] &
               ((count_reg & ((15'h0001 << tap_idx) - 15'h0001)) ==
                ((15'h0001 << tap_idx) - 15'h0001));
  end

  assign dv.rollover = dv.run & dv.advance & tap_rise;

  // chain held at zero while off, counts source ticks while on
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count_reg <= '0;
    end else if (ce_i) begin
      if (!dv.run) begin
        count_reg <= '0;
      end else if (dv.advance) begin
        count_reg <= count_reg + 15'h0001;
      end
    end
  end

endmodule

//--- rtl/ptb_top.sv
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "ptb_defs.svh"
module ptb_top
  import ptb_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  // tick sources and low power state
  input  wire logic        external_clock_i,
  input  wire logic        external_clock_gen_on_i,
  input  wire logic        oscillator_run_in_stop_i,
  input  wire logic        wait_mode_i,
  input  wire logic        stop_mode_i,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // interrupt request / stop wakeup
  output logic             irq_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  ptb_div_if  div_bus ();

  logic       ext_clk_sync;
  logic       ext_clk_dly_reg;
  logic       ext_tick;
  logic       tick;
  logic       stop_halt;
  logic       access_blocked;

  logic       rate_counter_on_reg;
  logic       rollover_irq_enable_reg;
  ptb_tap_t   tap_select_reg;
  logic       rollover_flag_reg;
  logic       overrun_reg;
  logic [1:0] mask_reg;

  logic        aw_held_reg;
  logic        w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        wr_byte0;
  logic        wr_ctl;
  logic        wr_sts;
  logic        wr_msk;
  logic        ack_hit;
  logic        sts_roll_clr;
  logic        sts_ovr_clr;
  logic [31:0] rd_word;
  ptb_resp_e   rd_resp;
  ptb_resp_e   wr_resp;

  // ****************************************************************
  // tick source selection
  // ****************************************************************

  // pin clock is sampled, so it must run well below core_clk_i
  ptb_sync u_ext_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .async_i    (external_clock_i),
    .sync_o     (ext_clk_sync)
  );

  // edge detect looks at the second stage only
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ext_clk_dly_reg <= 1'b0;
    end else if (ce_i) begin
      ext_clk_dly_reg <= ext_clk_sync;
    end
  end

  assign ext_tick = ext_clk_sync & ~ext_clk_dly_reg;

  // internal clock is the core clock itself: one tick per cycle
  assign tick = external_clock_gen_on_i ? ext_tick : 1'b1;

  // without the oscillator kept on, stop freezes the chain
  assign stop_halt = stop_mode_i & ~oscillator_run_in_stop_i;

  // wait mode only blocks register access: the chain keeps running
  assign access_blocked = wait_mode_i | stop_mode_i;

  // ****************************************************************
  // divider
  // ****************************************************************
  assign div_bus.run     = rate_counter_on_reg;
  assign div_bus.advance = tick & ~stop_halt;
  assign div_bus.tap_sel = tap_select_reg;

  ptb_divider u_divider (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .dv         (div_bus.div)
  );

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************

  // ready only while the slot is free; frozen clock means no handshake
  assign s_axi_awready = ce_i & ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ce_i & ~w_held_reg & ~s_axi_bvalid;
  assign wr_fire       = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  // address and data accepted in either order
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // decode; low-power modes swallow the write and report an error
  assign wr_byte0 = wr_fire & w_strb_reg[0] & ~access_blocked;
  assign wr_ctl   = wr_byte0 & ({aw_addr_reg[11:2], 2'b00} == `PTB_OFF_CONTROL);
  assign wr_sts   = wr_byte0 & ({aw_addr_reg[11:2], 2'b00} == `PTB_OFF_STATUS);
  assign wr_msk   = wr_byte0 & ({aw_addr_reg[11:2], 2'b00} == `PTB_OFF_MASK);

  always_comb begin
    wr_resp = PTB_RESP_SLVERR;
    if (!access_blocked &&
        (({aw_addr_reg[11:2], 2'b00} == `PTB_OFF_CONTROL) ||
         ({aw_addr_reg[11:2], 2'b00} == `PTB_OFF_STATUS) ||
         ({aw_addr_reg[11:2], 2'b00} == `PTB_OFF_MASK))) begin
      wr_resp = PTB_RESP_OKAY;
    end
  end

  // response held until the master takes it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PTB_RESP_OKAY;
    end else if (ce_i) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_resp;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************

  // enables come out of reset cleared; tap is not guarded by hardware,
  // changing it while on merely shifts the next event
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rate_counter_on_reg     <= `PTB_RST_ON;
      rollover_irq_enable_reg <= `PTB_RST_IRQEN;
      tap_select_reg          <= `PTB_RST_TAP;
    end else if (ce_i && wr_ctl) begin
      rate_counter_on_reg     <= w_data_reg[`PTB_CTL_ON_BIT];
      rollover_irq_enable_reg <= w_data_reg[`PTB_CTL_IRQEN_BIT];
      tap_select_reg          <= w_data_reg[`PTB_CTL_TAP_MSB:`PTB_CTL_TAP_LSB];
    end
  end

  // ****************************************************************
  // rollover flag and event status
  // ****************************************************************
  assign ack_hit      = wr_ctl & w_data_reg[`PTB_CTL_ACK_BIT];
  assign sts_roll_clr = wr_sts & w_data_reg[`PTB_EVT_ROLL_BIT];
  assign sts_ovr_clr  = wr_sts & w_data_reg[`PTB_EVT_OVR_BIT];

  // flag bit of a control write is ignored; a rollover beats any clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rollover_flag_reg <= 1'b0;
    end else if (ce_i) begin
      if (div_bus.rollover) begin
        rollover_flag_reg <= 1'b1;
      end else if (ack_hit || sts_roll_clr) begin
        rollover_flag_reg <= 1'b0;
      end
    end
  end

  // overrun: rollover while the previous one is still pending
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      overrun_reg <= 1'b0;
    end else if (ce_i) begin
      if (div_bus.rollover && rollover_flag_reg) begin
        overrun_reg <= 1'b1;
      end else if (sts_ovr_clr) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // mask resets open so the control enable alone governs rollover
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mask_reg <= `PTB_RST_MASK;
    end else if (ce_i && wr_msk) begin
      mask_reg <= w_data_reg[1:0];
    end
  end

  // level request; also serves as the wakeup from stop
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= (rollover_flag_reg & rollover_irq_enable_reg &
                mask_reg[`PTB_EVT_ROLL_BIT]) |
               (overrun_reg & mask_reg[`PTB_EVT_OVR_BIT]);
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  assign s_axi_arready = ce_i & ~s_axi_rvalid;

  // read mux; acknowledge position always reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = PTB_RESP_OKAY;
    if (access_blocked) begin
      rd_resp = PTB_RESP_SLVERR;
    end else if ({s_axi_araddr[11:2], 2'b00} == `PTB_OFF_CONTROL) begin
      rd_word[`PTB_CTL_ON_BIT]                   = rate_counter_on_reg;
      rd_word[`PTB_CTL_IRQEN_BIT]                = rollover_irq_enable_reg;
      rd_word[`PTB_CTL_ACK_BIT]                  = 1'b0;
      rd_word[`PTB_CTL_TAP_MSB:`PTB_CTL_TAP_LSB] = tap_select_reg;
      rd_word[`PTB_CTL_FLAG_BIT]                 = rollover_flag_reg;
    end else if ({s_axi_araddr[11:2], 2'b00} == `PTB_OFF_STATUS) begin
      rd_word[`PTB_EVT_ROLL_BIT] = rollover_flag_reg;
      rd_word[`PTB_EVT_OVR_BIT]  = overrun_reg;
    end else if ({s_axi_araddr[11:2], 2'b00} == `PTB_OFF_MASK) begin
      rd_word[1:0] = mask_reg;
    end else begin
      rd_resp = PTB_RESP_SLVERR;
    end
  end

  // data captured at the address handshake, held until taken
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= PTB_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_resp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- bench/ptb_top_chk.sv
`timescale 1ns/10ps
// ****************************************************************
// port-level checker for the timebase block
// ****************************************************************
module ptb_top_chk
  import ptb_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic        oscillator_run_in_stop_i,
  input wire logic        wait_mode_i,
  input wire logic        stop_mode_i,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq_o
);
  logic frozen;
  // stop mode with the oscillator off: no tick may reach the chain
  assign frozen = stop_mode_i && !oscillator_run_in_stop_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_reset_quiet: assert property ($fell(srst_i) |-> !irq_o ##1 !irq_o)
    else $error("irq raised straight after reset");
  a_wr_refused: assert property (
    $rose(s_axi_bvalid) && $past(wait_mode_i || stop_mode_i)
    && $past(wait_mode_i || stop_mode_i, 2) |-> s_axi_bresp == PTB_RESP_SLVERR)
    else $error("write accepted in low power mode");
  a_rd_refused: assert property (
    $rose(s_axi_rvalid) && $past(wait_mode_i || stop_mode_i)
    |-> s_axi_rresp == PTB_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("read served in low power mode");
  a_ack_zero: assert property (s_axi_rvalid && s_axi_rresp == PTB_RESP_OKAY
    |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[3])
    else $error("acknowledge or upper bits read nonzero");
  a_stop_frozen: assert property ($rose(irq_o)
    |-> !($past(frozen) && $past(frozen, 2) && $past(frozen, 3)))
    else $error("irq rose while stopped without oscillator");
  a_irq_sticky: assert property ($fell(irq_o) |-> $past(s_axi_bvalid))
    else $error("irq dropped without a register write");
  a_ready_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

bind ptb_top ptb_top_chk u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i),
  .oscillator_run_in_stop_i(oscillator_run_in_stop_i),
  .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq_o(irq_o)
);

//--- bench/ptb_far_end.sv
`timescale 1ns/10ps
// ****************************************************************
// clock generator and cpu interrupt side
// ****************************************************************
module ptb_far_end (
  input  wire logic core_clk_i,
  input  wire logic run_i,
  input  wire logic irq_i,
  output logic      external_clock_o,
  output int        wake_count_o
);
  int   phase = 0;
  logic irq_q = 1'b0;
  initial external_clock_o = 1'b0;
  initial wake_count_o = 0;
  // eight core cycles per period, well under half the core rate; still when idle
  always @(posedge core_clk_i) begin
    phase <= run_i ? (phase + 1) % 8 : 0;
    external_clock_o <= run_i && (phase >= 4);
  end
  // every rising request counts as a wakeup of the cpu
  always @(posedge core_clk_i) begin
    irq_q <= irq_i;
    if (irq_i && !irq_q) wake_count_o <= wake_count_o + 1;
  end
endmodule

//--- bench/test_periodic_timebase_tick.sv
`timescale 1ns/10ps
`include "ptb_defs.svh"
module test_periodic_timebase_tick;
  import ptb_pkg::*;
  // ****************************************************************
  // signals and model state
  // ****************************************************************
  localparam logic [11:0] CTL = `PTB_OFF_CONTROL;
  localparam logic [11:0] STA = `PTB_OFF_STATUS;
  localparam logic [11:0] MSK = `PTB_OFF_MASK;
  logic        core_clk_i = 1'b0;
  logic        srst_i     = 1'b1;
  logic        ce         = 1'b1;
  logic        gen_on = 1'b0, osc_stop = 1'b0, wait_m = 1'b0, stop_m = 1'b0, ext_run = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rdata, d;
  logic        awr, wrdy, bv, arr, rv, irq, ext_clk;
  logic [1:0]  bresp, rresp, r;
  int          fail_count = 0, comparisons = 0, cyc = 0, wakes, w0, t0, t1, n, m_ctl;
  int          exp_q[$];

  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;

  ptb_top DUT (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce),
    .external_clock_i(ext_clk), .external_clock_gen_on_i(gen_on),
    .oscillator_run_in_stop_i(osc_stop), .wait_mode_i(wait_m), .stop_mode_i(stop_m),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .irq_o(irq));
  ptb_far_end far (.core_clk_i(core_clk_i), .run_i(ext_run), .irq_i(irq),
    .external_clock_o(ext_clk), .wake_count_o(wakes));

  // ****************************************************************
  // bus tasks, comparison and closing
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk_i);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= v; bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!(bv && bready));
    rs = bresp;
    bready <= 1'b0;
  endtask
  // rready comes late on purpose so the slave must hold its answer
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk_i);
    arv <= 1'b1; ara <= a;
    do @(posedge core_clk_i); while (!arr);
    arv <= 1'b0;
    do @(posedge core_clk_i); while (!rv);
    rready <= 1'b1;
    @(posedge core_clk_i);
    v = rdata; rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_irq(input logic lvl, output int t);
    int k;
    k = 0;
    do begin @(posedge core_clk_i); k++; end while (irq !== lvl && k < 50000);
    if (irq !== lvl) fail_count++;
    t = cyc;
  endtask
  task automatic off_ack;
    wr(CTL, 32'h0, r);
    wr(CTL, 32'h8, r);
    wr(STA, 32'h3, r); // a pending overrun would hold irq up
  endtask
  function automatic int div_of(input int t);
    return (t >= 3) ? (8 << (7 - t)) : (t == 0) ? 32768 : (t == 1) ? 8192 : 2048;
  endfunction

  initial begin
    #(40 * 80000);
    fail_count++;
    stop_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(60));
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(CTL, d, r); chk("ctl reset", d, 32'h0);
    rd(MSK, d, r); chk("mask reset", d, 32'h3);
    wr(CTL, ($urandom & 32'hffffff00) | 32'h88, r); // flag and acknowledge only
    rd(CTL, d, r); chk("ctl ro bits", d, 32'h0);
    rd(12'h00c, d, r); chk("unmapped", {d[29:0], r}, {30'h0, PTB_RESP_SLVERR});
    $display("test registers done");
    // every tap code; off before any rate change, then on from zero
    for (int t = 7; t >= 0; t--) begin
      n = div_of(t);
      m_ctl = (t << 4) | 6;
      exp_q.push_back(n / 2 + 1);
      exp_q.push_back(n + n / 2 + 1);
      wr(CTL, m_ctl | ($urandom & 32'hffff0000), r); t0 = cyc;
      wait_irq(1'b1, t1); chk("first event", t1 - t0, exp_q.pop_front());
      wr(CTL, m_ctl | 8, r); wait_irq(1'b0, t1);
      wait_irq(1'b1, t1); chk("next event", t1 - t0, exp_q.pop_front());
      rd(CTL, d, r); chk("ctl flag", d, m_ctl | 32'h80);
      off_ack();
    end
    $display("test rates done");
    wr(CTL, 32'h72, r);
    repeat (8) @(posedge core_clk_i);
    chk("irq disabled", irq, 1'b0);
    rd(STA, d, r); chk("status roll", d[0], 1'b1);
    wr(MSK, 32'h0, r); wr(CTL, 32'h76, r);
    repeat (2) @(posedge core_clk_i);
    chk("irq masked", irq, 1'b0);
    wr(MSK, 32'h3, r);
    repeat (2) @(posedge core_clk_i);
    chk("irq enabled", irq, 1'b1);
    wr(CTL, 32'h0, r); wr(STA, 32'h3, r);
    rd(STA, d, r); chk("status clear", d, 32'h0);
    chk("irq cleared", irq, 1'b0);
    $display("test interrupt done");
    wr(CTL, 32'h56, r); t0 = cyc;
    wait_m <= 1'b1;
    wr(CTL, 32'h0, r); chk("wait write", r, PTB_RESP_SLVERR);
    wait_irq(1'b1, t1); chk("wait event", t1 - t0, 32'd17);
    wait_m <= 1'b0;
    off_ack();
    wr(CTL, 32'h56, r);
    stop_m <= 1'b1;
    wr(CTL, 32'h0, r); chk("stop write", r, PTB_RESP_SLVERR);
    rd(CTL, d, r); chk("stop read", {d[29:0], r}, {30'h0, PTB_RESP_SLVERR});
    repeat (40) @(posedge core_clk_i);
    chk("stop frozen", irq, 1'b0);
    w0 = wakes; osc_stop <= 1'b1; t0 = cyc;
    wait_irq(1'b1, t1); @(posedge core_clk_i);
    chk("stop wake", (t1 - t0 < 30) && (wakes - w0 == 1), 1'b1);
    stop_m <= 1'b0; osc_stop <= 1'b0;
    off_ack();
    // clock enable low: one tick before the freeze, three after it
    wr(CTL, 32'h76, r); ce <= 1'b0;
    repeat (40) @(posedge core_clk_i);
    chk("ce frozen", irq, 1'b0);
    ce <= 1'b1; t0 = cyc;
    wait_irq(1'b1, t1); chk("ce resume", t1 - t0, 32'd5);
    off_ack();
    $display("test low power done");
    gen_on <= 1'b1;
    wr(CTL, 32'h76, r);
    repeat (40) @(posedge core_clk_i);
    chk("ext idle", irq, 1'b0);
    ext_run <= 1'b1; t0 = cyc;
    wait_irq(1'b1, t1); chk("ext event", (t1 - t0 >= 24) && (t1 - t0 <= 44), 1'b1);
    ext_run <= 1'b0;
    off_ack();
    gen_on <= 1'b0;
    $display("test external clock done");
    stop_test();
  end
endmodule
